// ==== hdl/pfac_pkg.sv ====
/*
 Package for the program flash access control block: register offsets,
 field positions, reset values, vectors, unlock keys and the sequencer
 states. It assumes a Wishbone slave with 32-bit data and byte offsets four apart.
*/
package pfac_pkg;
   localparam int PC_WIDTH     = 15;
   localparam int ROW_WIDTH    = 14;
   localparam int ADR_W        = 5;

   localparam logic [ADR_W-1:0] OFS_ADDR_LOW  = 5'h00;
   localparam logic [ADR_W-1:0] OFS_ADDR_HIGH = 5'h04;
   localparam logic [ADR_W-1:0] OFS_CONTROL   = 5'h08;
   localparam logic [ADR_W-1:0] OFS_UNLOCK    = 5'h0c;
   localparam logic [ADR_W-1:0] OFS_STATUS    = 5'h10;

   localparam int BIT_INITIATE = 0;
   localparam int BIT_PERMIT   = 1;
   localparam int BIT_ERASE    = 2;
   localparam int BIT_REGION   = 6;
   localparam int BIT_BUSY     = 0;
   localparam int BIT_ARMED    = 1;
   localparam int PC_LSB       = 16;
   localparam int HIGH_BITS    = 6;

   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] ADDR_RESET    = 8'h00;
   localparam logic [HIGH_BITS-1:0] ADDR_HIGH_RESET = 6'h00;
   localparam logic [7:0] KEY_FIRST     = 8'h55;
   localparam logic [7:0] KEY_SECOND    = 8'haa;

   localparam logic [PC_WIDTH-1:0] RESET_VECTOR = 15'h0000;
   localparam logic [PC_WIDTH-1:0] IRQ_VECTOR   = 15'h0004;

   typedef enum logic [2:0]
   {
      PFAC_KEY_IDLE  = 3'b001,
      PFAC_KEY_HALF  = 3'b010,
      PFAC_KEY_ARMED = 3'b100
   } pfac_key_type;
endpackage

// ==== hdl/pfac_unlock.sv ====
/*
 Unlock key sequencer: arms only after the first key and then the second
 key arrive as consecutive writes. Assumes pulses on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pfac_unlock
(
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       key_wr,
   input  wire logic [7:0] key_data,
   input  wire logic       other_wr,
   output logic            armed
);
   pfac_pkg::pfac_key_type state_reg;

   // Any unrelated write on byte lane 0 breaks the sequence, so keys must be back to back
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         state_reg <= pfac_pkg::PFAC_KEY_IDLE;
      else if (other_wr)
         state_reg <= pfac_pkg::PFAC_KEY_IDLE;
      else if (key_wr)
      begin
         unique case (state_reg)
            pfac_pkg::PFAC_KEY_IDLE:
               state_reg <= (key_data == pfac_pkg::KEY_FIRST) ?
                  pfac_pkg::PFAC_KEY_HALF : pfac_pkg::PFAC_KEY_IDLE;
            pfac_pkg::PFAC_KEY_HALF:
               state_reg <= (key_data == pfac_pkg::KEY_SECOND) ?
                  pfac_pkg::PFAC_KEY_ARMED : pfac_pkg::PFAC_KEY_IDLE;
            pfac_pkg::PFAC_KEY_ARMED:
               state_reg <= (key_data == pfac_pkg::KEY_FIRST) ?
                  pfac_pkg::PFAC_KEY_HALF : pfac_pkg::PFAC_KEY_IDLE;
            default:
               state_reg <= pfac_pkg::PFAC_KEY_IDLE;
         endcase
      end
   end

   assign armed = (state_reg == pfac_pkg::PFAC_KEY_ARMED);
endmodule // pfac_unlock
`default_nettype wire

// ==== hdl/pfac_top.sv ====
/*
 Program flash access control: Wishbone register slave, unlock check,
 erase and write launch towards the flash macro, and the program counter
 that is held while an operation runs.
 Assumes the flash macro and the core share mclk; flash_done is a pulse.
 Macro timing is not modelled here; only flash_done ends an operation.
*/
// Functional notes
// - Program counter is 15 bits, addressing 32K words of 14 bits.
// - Fetch starts at word 0000h after reset; interrupts vector to 0004h.
// - Region bit cleared targets the user program flash array.
// - Row address is low byte plus six high bits.
// - Erase bit makes next operation a row erase; needs write permit set.
// - Keys 55h then AAh must precede initiate; otherwise initiate ignored.
// - A started erase completes before the next instruction executes.
`timescale 1ns/1ps
`default_nettype none
module pfac_top
#(
   parameter int PCW = pfac_pkg::PC_WIDTH
)
(
   input  wire logic                      mclk,
   input  wire logic                      sys_rst,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [pfac_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   input  wire logic                      fetch_step,
   input  wire logic                      irq_take,
   output logic      [PCW-1:0]            prog_counter,
   output logic                           cpu_hold,
   output logic                           flash_erase,
   output logic                           flash_write,
   output logic                           region_select,
   output logic [pfac_pkg::ROW_WIDTH-1:0] flash_row_addr,
   input  wire logic                      flash_done
);
   logic [7:0]     flash_addr_low_reg;
   logic [5:0]     flash_addr_high_reg;
   logic [7:0]     flash_control_reg;
   logic           busy_reg;
   logic           erase_reg;
   logic           write_reg;
   logic [PCW-1:0] pc_reg;
   logic [PCW-1:0] pc_next;
   logic           ack_reg;
   logic [31:0]    rdata_reg;
   logic [31:0]    read_word;
   logic           access;
   logic           wr_lane;
   logic           key_wr;
   logic           ctrl_wr;
   logic           other_wr;
   logic           armed;
   logic           launch;
   logic           permit_new;

   assign access   = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr_lane  = access & wb_we_i & wb_sel_i[0];
   assign key_wr   = wr_lane & (wb_adr_i == pfac_pkg::OFS_UNLOCK);
   assign ctrl_wr  = wr_lane & (wb_adr_i == pfac_pkg::OFS_CONTROL);
   assign other_wr = wr_lane & ~key_wr;
   assign permit_new = wb_dat_i[pfac_pkg::BIT_PERMIT];

   // Initiate only counts when armed, permitted and idle
   assign launch = ctrl_wr & wb_dat_i[pfac_pkg::BIT_INITIATE] & armed
                   & permit_new & ~busy_reg;

   // Keys still advance while busy; an initiate while busy is dropped, not queued
   pfac_unlock u_unlock
   (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .key_wr   (key_wr),
      .key_data (wb_dat_i[7:0]),
      .other_wr (other_wr),
      .armed    (armed)
   );

   // Classic cycle: one wait state, ack dropped in the cycle after
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         ack_reg <= 1'b0;
      else
         ack_reg <= access;
   end

   // Row freezes while busy so the macro sees a steady target
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         flash_addr_low_reg <= pfac_pkg::ADDR_RESET;
      else if (wr_lane && wb_adr_i == pfac_pkg::OFS_ADDR_LOW && !busy_reg)
         flash_addr_low_reg <= wb_dat_i[7:0];
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         flash_addr_high_reg <= pfac_pkg::ADDR_HIGH_RESET;
      else if (wr_lane && wb_adr_i == pfac_pkg::OFS_ADDR_HIGH && !busy_reg)
         flash_addr_high_reg <= wb_dat_i[pfac_pkg::HIGH_BITS-1:0];
   end

   // Initiate bit is set only by launch; software cannot fake it
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         flash_control_reg <= pfac_pkg::CONTROL_RESET;
      else if (ctrl_wr && !busy_reg)
      begin
         flash_control_reg <= wb_dat_i[7:0];
         flash_control_reg[pfac_pkg::BIT_INITIATE] <= launch;
      end
      else if (busy_reg && flash_done)
         flash_control_reg[pfac_pkg::BIT_INITIATE] <= 1'b0;
   end

   // Busy gates every settings write until the macro answers
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         busy_reg <= 1'b0;
      else if (launch)
         busy_reg <= 1'b1;
      else if (flash_done)
         busy_reg <= 1'b0;
   end

   // Kind comes from the launch word itself, not the stored bit
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         erase_reg <= 1'b0;
      else if (launch)
         erase_reg <= wb_dat_i[pfac_pkg::BIT_ERASE];
      else if (flash_done)
         erase_reg <= 1'b0;
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         write_reg <= 1'b0;
      else if (launch)
         write_reg <= ~wb_dat_i[pfac_pkg::BIT_ERASE];
      else if (flash_done)
         write_reg <= 1'b0;
   end

   assign flash_erase    = erase_reg;
   assign flash_write    = write_reg;
   assign region_select  = flash_control_reg[pfac_pkg::BIT_REGION];
   assign flash_row_addr = {flash_addr_high_reg, flash_addr_low_reg};

   // Core stalls from the launching write until the macro reports done
   assign cpu_hold = busy_reg | launch;

   // Hold beats an interrupt so a running erase is never cut short
   always_comb
   begin
      pc_next = pc_reg;
      if (cpu_hold)
         pc_next = pc_reg;
      else if (irq_take)
         pc_next = pfac_pkg::IRQ_VECTOR;
      else if (fetch_step)
         pc_next = pc_reg + 1'b1;
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         pc_reg <= pfac_pkg::RESET_VECTOR;
      else
         pc_reg <= pc_next;
   end

   assign prog_counter = pc_reg;

   // Read word from live state; registered so data stands with ack
   always_comb
   begin
      read_word = 32'h0000_0000;
      unique case (wb_adr_i)
         pfac_pkg::OFS_ADDR_LOW:
            read_word[7:0] = flash_addr_low_reg;
         pfac_pkg::OFS_ADDR_HIGH:
            read_word[5:0] = flash_addr_high_reg;
         pfac_pkg::OFS_CONTROL:
            read_word[7:0] = flash_control_reg;
         pfac_pkg::OFS_STATUS:
         begin
            read_word[pfac_pkg::BIT_BUSY]  = busy_reg;
            read_word[pfac_pkg::BIT_ARMED] = armed;
            read_word[pfac_pkg::PC_LSB +: PCW] = pc_reg;
         end
         // Key offset reads zero so keys never echo back
         default:
            read_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         rdata_reg <= 32'h0000_0000;
      else if (access && !wb_we_i)
         rdata_reg <= read_word;
   end

   assign wb_dat_o = rdata_reg;
   assign wb_ack_o = ack_reg;
endmodule // pfac_top
`default_nettype wire

// ==== bench/pfac_assertions.sv ====
/*
 Port timing checker for pfac_top.
 Assumes it is bound to pfac_top from the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module pfac_assertions
#(
   parameter int PCW = pfac_pkg::PC_WIDTH
)
(
   input wire logic           mclk,
   input wire logic           sys_rst,
   input wire logic           wb_cyc_i,
   input wire logic           wb_stb_i,
   input wire logic           wb_ack_o,
   input wire logic           fetch_step,
   input wire logic           irq_take,
   input wire logic [PCW-1:0] prog_counter,
   input wire logic           cpu_hold,
   input wire logic           flash_erase,
   input wire logic           flash_write,
   input wire logic           flash_done
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   op_hold_a: assert property (flash_erase || flash_write |-> cpu_hold)
      else $error("operation runs without core hold");
   pc_frozen_a: assert property (cpu_hold |=> $stable(prog_counter))
      else $error("program counter moved during hold");
   irq_vec_a: assert property (irq_take && !cpu_hold |=>
      prog_counter == pfac_pkg::IRQ_VECTOR)
      else $error("interrupt vector wrong");
   pc_step_a: assert property (fetch_step && !irq_take && !cpu_hold |=>
      prog_counter == PCW'($past(prog_counter) + 1'b1))
      else $error("program counter step wrong");
   done_ends_a: assert property (flash_done |=> !flash_erase && !flash_write)
      else $error("operation not ended by done");
   one_kind_a: assert property (!(flash_erase && flash_write))
      else $error("erase and write together");
endmodule // pfac_assertions
`default_nettype wire

// ==== bench/pfac_flash_model.sv ====
/*
 Flash macro stand-in: pulses done a chosen number of cycles after an
 operation starts. Assumes the same clock and reset as pfac_top.
*/
`timescale 1ns/1ps
`default_nettype none
module pfac_flash_model
(
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       flash_erase,
   input  wire logic       flash_write,
   input  wire logic [3:0] delay,
   output logic            flash_done
);
   logic [4:0] wait_reg;
   wire        run = (flash_erase | flash_write) & ~flash_done;

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wait_reg   <= 5'h00;
         flash_done <= 1'b0;
      end
      else
      begin
         flash_done <= run && (wait_reg == {1'b0, delay});
         wait_reg   <= run ? wait_reg + 5'h01 : 5'h00;
      end
   end
endmodule // pfac_flash_model
`default_nettype wire

// ==== bench/pfac_top_tb.sv ====
/*
 Self-checking bench for pfac_top: Wishbone traffic, unlock sequence,
 launches and program counter. Assumes the flash model and checker.
*/
`timescale 1ns/1ps
`default_nettype none
module pfac_top_tb;
   localparam logic [4:0] al = pfac_pkg::OFS_ADDR_LOW;
   localparam logic [4:0] ah = pfac_pkg::OFS_ADDR_HIGH;
   localparam logic [4:0] ct = pfac_pkg::OFS_CONTROL;
   localparam logic [4:0] uk = pfac_pkg::OFS_UNLOCK;
   localparam logic [4:0] st = pfac_pkg::OFS_STATUS;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] dout, rdat;
   logic        ack, hold, ers, wrt, rsel, done;
   logic        step = 1'b0;
   logic        irq = 1'b0;
   logic [3:0]  dly = 4'h0;
   logic [14:0] pc;
   logic [13:0] row;
   logic [7:0]  lo, hi, ctl [3];
   int          bad_count, comparisons, cycles, n;

   always #20 mclk = ~mclk;

   pfac_top dut (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
      .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
      .fetch_step(step), .irq_take(irq), .prog_counter(pc),
      .cpu_hold(hold), .flash_erase(ers), .flash_write(wrt),
      .region_select(rsel), .flash_row_addr(row), .flash_done(done));
   pfac_flash_model macro (.mclk(mclk), .sys_rst(sys_rst),
      .flash_erase(ers), .flash_write(wrt), .delay(dly),
      .flash_done(done));

   function automatic logic [14:0] pc_after(input int steps);
      return 15'(steps);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [4:0] a,
      input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge mclk);
      while (ack !== 1'b1)
         @(posedge mclk);
      rdat = dout;
      cyc <= 1'b0;
   endtask

   task automatic unlock();
      irq <= 1'b0;
      wb(1'b1, uk, 32'h0000_0055);
      wb(1'b1, uk, 32'h0000_00aa);
   endtask

   task automatic stop_test();
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Ceiling well above the few hundred cycles the sequence needs
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         bad_count++;
         stop_test();
      end
   end

   initial
   begin
      ctl = '{8'h07, 8'h03, 8'h05};
      void'($urandom(32'h0000_bc64));
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;
      wb(1'b0, st, 32'h0000_0000);
      chk(rdat, 32'h0000_0000);
      n = $urandom_range(40, 1);
      @(posedge mclk);
      step <= 1'b1;
      repeat (n) @(posedge mclk);
      step <= 1'b0;
      wb(1'b0, st, 32'h0000_0000);
      chk(rdat[31:16], pc_after(n));
      irq <= 1'b1;
      @(posedge mclk);
      irq <= 1'b0;
      wb(1'b0, st, 32'h0000_0000);
      chk(rdat[31:16], pfac_pkg::IRQ_VECTOR);
      wb(1'b1, ct, 32'h0000_0007);
      chk(ers, 1'b0);
      wb(1'b1, uk, 32'h0000_00aa);
      wb(1'b1, uk, 32'h0000_0055);
      wb(1'b1, ct, 32'h0000_0007);
      chk(ers, 1'b0);
      unlock();
      wb(1'b1, al, 32'h0000_0000);
      wb(1'b1, ct, 32'h0000_0007);
      chk(ers, 1'b0);
      wb(1'b1, ct, 32'h0000_0040);
      chk(rsel, 1'b1);
      for (int k = 0; k < 3; k++)
      begin
         lo = 8'($urandom);
         hi = 8'($urandom);
         dly <= 4'($urandom);
         wb(1'b1, al, {24'h00_0000, lo});
         wb(1'b1, ah, {24'h00_0000, hi});
         unlock();
         // Launch word also clears the region bit for the user array
         wb(1'b1, ct, {24'h00_0000, ctl[k]});
         chk(ers, k == 0);
         chk(wrt, k == 1);
         chk(rsel, 1'b0);
         chk(row, {hi[5:0], lo});
         chk(hold, ctl[k][pfac_pkg::BIT_PERMIT]);
         step <= 1'b1;
         @(posedge mclk);
         while (hold === 1'b1)
            @(posedge mclk);
         step <= 1'b0;
         wb(1'b0, ct, 32'h0000_0000);
         chk(rdat[0], 1'b0);
      end
      wb(1'b0, 5'h14, 32'h0000_0000);
      chk(rdat, 32'h0000_0000);
      // Mid-run reset must drop the armed state and the counter
      unlock();
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      wb(1'b0, st, 32'h0000_0000);
      chk(rdat, 32'h0000_0000);
      stop_test();
   end
endmodule // pfac_top_tb

bind pfac_top pfac_assertions #(.PCW(PCW)) checker_inst (.mclk(mclk),
   .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .fetch_step(fetch_step), .irq_take(irq_take),
   .prog_counter(prog_counter), .cpu_hold(cpu_hold),
   .flash_erase(flash_erase), .flash_write(flash_write),
   .flash_done(flash_done));
`default_nettype wire
